//--- include/bw_cfg_pkg.sv
/*
 * Constants and types for the loop bandwidth configuration block.
 * Assumes an 8-bit register port; bandwidths are given in 0.1 Hz units.
 */
package bw_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP_MODE_OFS = 8'h3B;
  localparam logic [7:0] SECONDARY_BW_OFS = 8'h66;
  localparam logic [7:0] LOCKED_BW_OFS = 8'h67;
  localparam logic [7:0] ACQUIRE_BW_OFS = 8'h68;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int AUTO_SWITCH_BIT = 7;
  localparam logic [1:0] SECONDARY_BW_RST = 2'h0;
  localparam logic [3:0] LOCKED_BW_RST = 4'h0;
  localparam logic [3:0] ACQUIRE_BW_RST = 4'h0;
  localparam logic AUTO_SWITCH_RST = 1'b0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Bandwidth values in tenths of a hertz
  // ----------------------------------------------------------------
  localparam logic [9:0] BW_0P1 = 10'h001;
  localparam logic [9:0] BW_0P3 = 10'h003;
  localparam logic [9:0] BW_0P6 = 10'h006;
  localparam logic [9:0] BW_1P2 = 10'h00C;
  localparam logic [9:0] BW_2P5 = 10'h019;
  localparam logic [9:0] BW_4 = 10'h028;
  localparam logic [9:0] BW_8 = 10'h050;
  localparam logic [9:0] BW_18 = 10'h0B4;
  localparam logic [9:0] BW_35 = 10'h15E;
  localparam logic [9:0] BW_70 = 10'h2BC;

  // Selected bandwidth with a flag for a defined code
  typedef struct packed {
    logic valid;
    logic [9:0] tenths;
  } bw_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : bw_cfg_pkg

//--- rtl/bw_code_decode.sv
/*
 * Decodes a four-bit main-path bandwidth code into a bandwidth.
 * Assumes a purely combinational use; the caller registers the result.
 */
`timescale 1ns/1ns
module bw_code_decode #(
  parameter bit ACQUIRE = 1'b0
) (
  input wire logic [3:0] code,
  output bw_cfg_pkg::bw_t bw
);
  import bw_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Code table
  // ----------------------------------------------------------------
  // Acquire table starts at 0.1 Hz and tops at 70 Hz; locked table
  // starts at 0.3 Hz and tops at 35 Hz
  always_comb begin
    bw = '0;
    bw.valid = 1'b1;
    case (code)
      4'h8: bw.tenths = ACQUIRE ? BW_0P1 : BW_0P3;
      4'h9: bw.tenths = ACQUIRE ? BW_0P3 : BW_0P6;
      4'hA: bw.tenths = ACQUIRE ? BW_0P6 : BW_1P2;
      4'hB: bw.tenths = ACQUIRE ? BW_1P2 : BW_2P5;
      4'hC: bw.tenths = ACQUIRE ? BW_2P5 : BW_4;
      4'hD: bw.tenths = ACQUIRE ? BW_4 : BW_8;
      4'hE: bw.tenths = ACQUIRE ? BW_8 : BW_18;
      4'hF: bw.tenths = ACQUIRE ? BW_18 : BW_35;
      4'h0: bw.tenths = ACQUIRE ? BW_35 : 10'h000;
      4'h1: bw.tenths = ACQUIRE ? BW_70 : 10'h000;
      default: bw.tenths = 10'h000;
    endcase
    // Codes outside the table carry no bandwidth
    if (bw.tenths == 10'h000) begin
      bw.valid = 1'b0;
    end
  end

endmodule : bw_code_decode

//--- rtl/dpll_bandwidth_config.sv
/*
 * Bandwidth configuration registers for the secondary and main loop paths.
 * Assumes a synchronous register port and a lock indication from the loop.
 */
`timescale 1ns/1ns
module dpll_bandwidth_config (
  input wire logic clk,
  input wire logic reset_n,
  input wire bw_cfg_pkg::reg_req_t regReq,
  output logic [7:0] regRdData,
  input wire logic mainLocked,
  output bw_cfg_pkg::bw_t secondaryBw,
  output bw_cfg_pkg::bw_t mainBw,
  output logic mainUsingAcquire
);
  import bw_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] secSel;
    logic [3:0] lockSel;
    logic [3:0] acqSel;
    logic autoSwitch;
    logic [7:0] rdData;
    bw_t secBw;
    bw_t mainBw;
    logic mainAcq;
  } state_t;

  state_t state_q;
  state_t state_d;
  bw_t lockedBw;
  bw_t acquireBw;
  logic useAcq;

  // Table lookups for the two main-path selectors
  bw_code_decode #(.ACQUIRE(1'b0)) lockedDecode (
    .code(state_q.lockSel),
    .bw(lockedBw)
  );
  bw_code_decode #(.ACQUIRE(1'b1)) acquireDecode (
    .code(state_q.acqSel),
    .bw(acquireBw)
  );

  // Acquire bandwidth only in automatic mode and while out of lock
  assign useAcq = state_q.autoSwitch & ~mainLocked;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes, read mux and bandwidth selection
  always_comb begin
    state_d = state_q;
    state_d.rdData = UNMAPPED_READ;
    if (regReq.wr) begin
      case (regReq.addr)
        SECONDARY_BW_OFS: state_d.secSel = regReq.wrData[1:0];
        LOCKED_BW_OFS: state_d.lockSel = regReq.wrData[3:0];
        ACQUIRE_BW_OFS: state_d.acqSel = regReq.wrData[3:0];
        LOOP_MODE_OFS: begin
          state_d.autoSwitch = regReq.wrData[AUTO_SWITCH_BIT];
        end
        default: ;
      endcase
    end
    if (regReq.rd) begin
      case (regReq.addr)
        SECONDARY_BW_OFS: state_d.rdData = {6'h00, state_q.secSel};
        LOCKED_BW_OFS: state_d.rdData = {4'h0, state_q.lockSel};
        ACQUIRE_BW_OFS: state_d.rdData = {4'h0, state_q.acqSel};
        LOOP_MODE_OFS: state_d.rdData = {state_q.autoSwitch, 7'h00};
        default: state_d.rdData = UNMAPPED_READ;
      endcase
    end
    // Secondary path table
    state_d.secBw.valid = 1'b1;
    case (state_q.secSel)
      2'h0: state_d.secBw.tenths = BW_18;
      2'h1: state_d.secBw.tenths = BW_35;
      2'h2: state_d.secBw.tenths = BW_70;
      default: begin
        state_d.secBw.tenths = 10'h000;
        state_d.secBw.valid = 1'b0;
      end
    endcase
    state_d.mainAcq = useAcq;
    state_d.mainBw = useAcq ? acquireBw : lockedBw;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All state, cleared by reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.secSel <= SECONDARY_BW_RST;
      state_q.lockSel <= LOCKED_BW_RST;
      state_q.acqSel <= ACQUIRE_BW_RST;
      state_q.autoSwitch <= AUTO_SWITCH_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  assign regRdData = state_q.rdData;
  assign secondaryBw = state_q.secBw;
  assign mainBw = state_q.mainBw;
  assign mainUsingAcquire = state_q.mainAcq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_sec_bw_map: assert property (
    (state_q.secSel == 2'h1) |=> (secondaryBw.tenths == BW_35)
      && secondaryBw.valid)
    else $error("Secondary code 01 did not give 35 Hz");

  a_sec_unused: assert property (
    (state_q.secSel == 2'h3) |=> !secondaryBw.valid)
    else $error("Secondary code 11 reported a bandwidth");

  a_locked_write_read: assert property (
    (regReq.wr && regReq.addr == LOCKED_BW_OFS) ##1
      (regReq.rd && !regReq.wr && regReq.addr == LOCKED_BW_OFS)
      |=> regRdData == {4'h0, $past(regReq.wrData[3:0], 2)})
    else $error("Locked selector read back wrong");

  a_locked_lowest: assert property (
    (state_q.lockSel == 4'h8 && !useAcq) |=> mainBw.tenths == BW_0P3)
    else $error("Locked code 1000 did not give 0.3 Hz");

  a_acq_write: assert property (
    (regReq.wr && regReq.addr == ACQUIRE_BW_OFS)
      |=> state_q.acqSel == $past(regReq.wrData[3:0]))
    else $error("Acquire selector not stored");

  a_acq_map: assert property (
    (state_q.acqSel == 4'hD && useAcq) |=> mainBw.tenths == BW_4
      && mainUsingAcquire)
    else $error("Acquire code 1101 did not give 4 Hz");

  a_acq_ceiling: assert property (
    mainUsingAcquire |-> mainBw.tenths <= BW_70)
    else $error("Acquire bandwidth above 70 Hz");

  a_mode_select: assert property (
    (!state_q.autoSwitch || mainLocked) |=> !mainUsingAcquire)
    else $error("Acquire bandwidth used while locked-only or locked");

  // Secondary path: remaining codes, storage and idle upper bits
  a_sec_low_code: assert property (
    (state_q.secSel == 2'h0) |=> (secondaryBw.tenths == BW_18)
      && secondaryBw.valid)
    else $error("Secondary code 00 did not give 18 Hz");

  a_sec_high_code: assert property (
    (state_q.secSel == 2'h2) |=> (secondaryBw.tenths == BW_70)
      && secondaryBw.valid)
    else $error("Secondary code 10 did not give 70 Hz");

  a_sec_store: assert property (
    (regReq.wr && regReq.addr == SECONDARY_BW_OFS)
      |=> state_q.secSel == $past(regReq.wrData[1:0]))
    else $error("Secondary selector not stored");

  a_sec_idle_bits: assert property (
    (regReq.rd && regReq.addr == SECONDARY_BW_OFS)
      |=> regRdData[7:2] == 6'h00)
    else $error("Secondary idle bits read nonzero");

  // Main path, locked selector
  a_locked_store: assert property (
    (regReq.wr && regReq.addr == LOCKED_BW_OFS)
      |=> state_q.lockSel == $past(regReq.wrData[3:0]))
    else $error("Locked selector not stored");

  a_locked_idle_bits: assert property (
    (regReq.rd && regReq.addr == LOCKED_BW_OFS)
      |=> regRdData[7:4] == 4'h0)
    else $error("Locked idle bits read nonzero");

  a_locked_top: assert property (
    (state_q.lockSel == 4'hF && !useAcq) |=> (mainBw.tenths == BW_35)
      && mainBw.valid)
    else $error("Locked code 1111 did not give 35 Hz");

  a_locked_unused: assert property (
    (state_q.lockSel < 4'h8 && !useAcq) |=> !mainBw.valid)
    else $error("Unused locked code reported a bandwidth");

  // Main path, acquire selector
  a_acq_read_back: assert property (
    (regReq.rd && regReq.addr == ACQUIRE_BW_OFS)
      |=> regRdData == {4'h0, $past(state_q.acqSel)})
    else $error("Acquire selector read back wrong");

  a_acq_lowest: assert property (
    (state_q.acqSel == 4'h8 && useAcq) |=> (mainBw.tenths == BW_0P1)
      && mainBw.valid)
    else $error("Acquire code 1000 did not give 0.1 Hz");

  a_acq_widest: assert property (
    (state_q.acqSel == 4'h1 && useAcq) |=> (mainBw.tenths == BW_70)
      && mainBw.valid)
    else $error("Acquire code 0001 did not give 70 Hz");

  a_acq_unused: assert property (
    (state_q.acqSel inside {[4'h2:4'h7]} && useAcq) |=> !mainBw.valid)
    else $error("Unused acquire code reported a bandwidth");

  // Mode selection
  a_mode_auto: assert property (
    (state_q.autoSwitch && !mainLocked) |=> mainUsingAcquire)
    else $error("Acquire bandwidth not used while unlocked in auto mode");

endmodule : dpll_bandwidth_config

//--- sim/tb_top.sv
/*
 * Self-checking bench for the loop bandwidth configuration block.
 * Assumes bw_cfg_pkg is compiled first and the design asserts itself.
 */
`timescale 1ns/1ns
module tb_top;
  import bw_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Signals and expected tables
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t regReq = '0;
  logic mainLocked = 1'b0;
  logic [7:0] regRdData;
  bw_t secondaryBw;
  bw_t mainBw;
  logic mainUsingAcquire;
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  // Expected bandwidths: valid flag in bit 10, tenths of a hertz below
  bw_t secTab [4] = '{11'h4B4, 11'h55E, 11'h6BC, 11'h000};
  bw_t lockTab [16] = '{11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0,
    11'h0, 11'h403, 11'h406, 11'h40C, 11'h419, 11'h428, 11'h450, 11'h4B4,
    11'h55E};
  bw_t acqTab [16] = '{11'h55E, 11'h6BC, 11'h0, 11'h0, 11'h0, 11'h0,
    11'h0, 11'h0, 11'h401, 11'h403, 11'h406, 11'h40C, 11'h419, 11'h428,
    11'h450, 11'h4B4};

  dpll_bandwidth_config dpll_bandwidth_config_i (
    .clk(clk),
    .reset_n(reset_n),
    .regReq(regReq),
    .regRdData(regRdData),
    .mainLocked(mainLocked),
    .secondaryBw(secondaryBw),
    .mainBw(mainBw),
    .mainUsingAcquire(mainUsingAcquire)
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk8

  task automatic chkBw(input bw_t exp, input bw_t got);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chkBw

  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wr <= 1'b1;
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : writeReg

  // Read data stands only in the cycle after the strobe
  task automatic readReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    chk8(exp, regRdData);
  endtask : readReg

  // Write with the read strobe in the very next cycle, no gap
  task automatic writeRead(input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    @(posedge clk);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wr <= 1'b1;
    @(posedge clk);
    regReq.wr <= 1'b0;
    regReq.rd <= 1'b1;
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1;
    chk8(exp, regRdData);
  endtask : writeRead

  // Lets a register change reach the bandwidth outputs
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : testDone

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      testDone();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chkBw(secTab[0], secondaryBw);
    readReg(SECONDARY_BW_OFS, 8'h00);
    readReg(LOCKED_BW_OFS, 8'h00);
    readReg(ACQUIRE_BW_OFS, 8'h00);
    readReg(8'h70, UNMAPPED_READ);
    @(posedge clk);
    #1;
    chk8(8'h00, regRdData);
    $display("reset and unmapped test done");
    // Every secondary code, idle upper bits set
    for (int c = 0; c < 4; c++) begin
      writeReg(SECONDARY_BW_OFS, 8'hFC | 8'(c));
      readReg(SECONDARY_BW_OFS, 8'(c));
      settle();
      chkBw(secTab[c], secondaryBw);
    end
    $display("secondary test done");
    // Every locked code while switching is off
    for (int c = 0; c < 16; c++) begin
      writeRead(LOCKED_BW_OFS, 8'hF0 | 8'(c), 8'(c));
      settle();
      chkBw(lockTab[c], mainBw);
      chk8(8'h00, {7'h0, mainUsingAcquire});
    end
    $display("locked test done");
    // Every acquire code with automatic switching, loop unlocked
    writeReg(LOOP_MODE_OFS, 8'h80);
    readReg(LOOP_MODE_OFS, 8'h80);
    for (int c = 0; c < 16; c++) begin
      writeReg(ACQUIRE_BW_OFS, 8'hF0 | 8'(c));
      readReg(ACQUIRE_BW_OFS, 8'(c));
      settle();
      chkBw(acqTab[c], mainBw);
      chk8(8'h01, {7'h0, mainUsingAcquire});
    end
    $display("acquire test done");
    // Lock gained, then switching turned off while still locked, then lock lost
    @(posedge clk);
    mainLocked <= 1'b1;
    settle();
    chkBw(lockTab[15], mainBw);
    chk8(8'h00, {7'h0, mainUsingAcquire});
    writeReg(LOOP_MODE_OFS, 8'h00);
    mainLocked <= 1'b0;
    settle();
    chkBw(lockTab[15], mainBw);
    chk8(8'h00, {7'h0, mainUsingAcquire});
    $display("switching test done");
    // Reset in mid-run clears every selector
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    chkBw('0, mainBw);
    chkBw('0, secondaryBw);
    @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chkBw(secTab[0], secondaryBw);
    readReg(LOCKED_BW_OFS, 8'h00);
    readReg(ACQUIRE_BW_OFS, 8'h00);
    $display("mid-run reset test done");
    testDone();
  end
endmodule : tb_top
